// ---- hw/tpi_top.sv ----
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tpi_defines.svh"
module tpi_top (
   // clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              ce,
   // apb
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // core side
   input  wire tpi_pkg::tpi_fetch_s fetch,
   input  wire tpi_pkg::tpi_op_s  op,
   input  wire logic              stack_pop,
   input  wire logic [7:0]        stack_ptr,
   input  wire logic              low_power,
   output logic      [7:0]        ir_q,
   output logic                   trap_pending_flag_q,
   output logic                   trap_ack_q,
   output logic      [14:0]       push_addr_q,
   output logic                   pc_load_q,
   output logic      [14:0]       pc_load_addr_q,
   output logic                   irq_req_q,
   output logic                   vec_valid_q,
   output logic      [7:0]        vec_low_q,
   output logic                   wake_q,
   output logic                   wake_isr_q,
   // pins
   input  wire logic              ext_interrupt_pin,
   input  wire logic [7:0]        port_pins
);
   import tpi_pkg::*;
   // ****************************************
   // apb slave
   // ****************************************
   logic       acc;
   logic       wr;
   logic       global_irq_enable_q;
   logic       port_group_irq_enable_q;
   logic       ext_irq_enable_q;
   logic       ext_edge_polarity_q;
   logic       ext_irq_pending_q;
   logic [7:0] wake_enable_mask_q;
   logic [7:0] wake_edge_select_q;
   logic [7:0] wake_pending_latch;
   tpi_svc_e   svc_q;
   logic [7:0] rd;
   logic       hit;
   // one wait state keeps every answer registered
   assign acc = psel & penable & ~pready;
   assign wr  = psel & penable & pready & pwrite;
   always_comb begin
      hit = 1'b1;
      rd  = 8'h00;
      unique case (paddr)
         `TPI_A_CTRL:      rd = {3'h0, ext_irq_pending_q, ext_edge_polarity_q, ext_irq_enable_q,
                                 port_group_irq_enable_q, global_irq_enable_q};
         `TPI_A_WAKE_EN:   rd = wake_enable_mask_q;
         `TPI_A_WAKE_EDGE: rd = wake_edge_select_q;
         `TPI_A_WAKE_PEND: rd = wake_pending_latch;
         `TPI_A_STATUS:    rd = {6'h00, svc_q};
         default:          hit = 1'b0;
      endcase
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (ce) begin
         pready  <= acc;
         prdata  <= (acc & ~pwrite) ? {24'h00_0000, rd} : 32'h0000_0000;
         pslverr <= acc & ~hit;
      end
   end
   // ****************************************
   // control registers
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         global_irq_enable_q     <= 1'b0;
         port_group_irq_enable_q <= 1'b0;
         ext_irq_enable_q        <= 1'b0;
         ext_edge_polarity_q     <= 1'b0;
      end else if (ce && wr && paddr == `TPI_A_CTRL) begin
         global_irq_enable_q     <= pwdata[`TPI_B_GIE];
         port_group_irq_enable_q <= pwdata[`TPI_B_PORT_GROUP_IRQ_ENABLE];
         ext_irq_enable_q        <= pwdata[`TPI_B_EXT_IRQ_ENABLE];
         ext_edge_polarity_q     <= pwdata[`TPI_B_EXT_EDGE_POLARITY];
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_enable_mask_q <= 8'h00;
         wake_edge_select_q <= 8'h00;
      end else if (ce && wr) begin
         if (paddr == `TPI_A_WAKE_EN) wake_enable_mask_q <= pwdata[7:0];
         if (paddr == `TPI_A_WAKE_EDGE) wake_edge_select_q <= pwdata[7:0];
      end
   end
   // ****************************************
   // external pin
   // ****************************************
   logic ext_prev_q;
   logic ext_edge;
   assign ext_edge = ext_edge_polarity_q ? (ext_prev_q & ~ext_interrupt_pin)
                                         : (~ext_prev_q & ext_interrupt_pin);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) ext_prev_q <= 1'b0;
      else if (ce) ext_prev_q <= ext_interrupt_pin;
   end
   // cleared only by software, edge wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) ext_irq_pending_q <= 1'b0;
      else if (ce) begin
         if (ext_edge) ext_irq_pending_q <= 1'b1;
         else if (wr && paddr == `TPI_A_CTRL) ext_irq_pending_q <= pwdata[`TPI_B_EXT_IRQ_PENDING];
      end
   end
   // ****************************************
   // port wake group
   // ****************************************
   // eight pins, one latch bit each
   tpi_wake u_wake (
      .pclk     (pclk),
      .presetn  (presetn),
      .ce       (ce),
      .pins     (port_pins),
      .edge_sel (wake_edge_select_q),
      .wr_en    (wr && paddr == `TPI_A_WAKE_PEND),
      .wr_data  (pwdata[7:0]),
      .pend_q   (wake_pending_latch)
   );
   logic port_any;
   logic port_act;
   logic ext_act;
   assign port_any = |(wake_pending_latch & wake_enable_mask_q);
   assign port_act = global_irq_enable_q & port_group_irq_enable_q & port_any;
   assign ext_act  = global_irq_enable_q & ext_irq_enable_q & ext_irq_pending_q;
   // ****************************************
   // fetch and trap
   // ****************************************
   logic       trap_fetch;
   logic [7:0] opcode;
   assign opcode     = fetch.present ? fetch.data : 8'h00;
   assign trap_fetch = fetch.valid & (opcode == `TPI_TRAP_OP);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) ir_q <= 8'h00;
      else if (ce && fetch.valid) ir_q <= opcode;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) trap_pending_flag_q <= 1'b0;
      else if (ce) begin
         if (trap_fetch) trap_pending_flag_q <= 1'b1;
         else if (op.clear_trap_pending_op) trap_pending_flag_q <= 1'b0;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trap_ack_q  <= 1'b0;
         push_addr_q <= 15'h0000;
      end else if (ce) begin
         trap_ack_q <= trap_fetch;
         if (trap_fetch) push_addr_q <= fetch.addr;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_load_q      <= 1'b0;
         pc_load_addr_q <= 15'h0000;
      end else if (ce) begin
         pc_load_q <= stack_pop && (stack_ptr >= `TPI_STACK_LIMIT);
         if (stack_pop && (stack_ptr >= `TPI_STACK_LIMIT)) pc_load_addr_q <= `TPI_PC_TOP;
      end
   end
   // ****************************************
   // arbitration and service state
   // ****************************************
   logic [7:0] vec;
   always_comb begin
      if (trap_pending_flag_q) vec = `TPI_V_TRAP;
      else if (ext_act) vec = `TPI_V_EXT;
      else if (port_act) vec = `TPI_V_PORT;
      else vec = `TPI_V_DEFAULT;
   end
   // vector byte loaded on every select cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vec_valid_q <= 1'b0;
         vec_low_q   <= `TPI_V_DEFAULT;
      end else if (ce) begin
         vec_valid_q <= op.vector_select_op;
         if (op.vector_select_op) vec_low_q <= vec;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) svc_q <= TPI_SVC_IDLE;
      else if (ce) begin
         unique case (svc_q)
            TPI_SVC_IDLE: begin
               if (op.vector_select_op && trap_pending_flag_q) svc_q <= TPI_SVC_TRAP;
               else if (op.vector_select_op && (ext_act || port_act)) svc_q <= TPI_SVC_MASK;
            end
            TPI_SVC_MASK: begin
               if (op.vector_select_op && trap_pending_flag_q) svc_q <= TPI_SVC_TRAP;
               else if (op.return_from_interrupt_op || op.return_and_skip_op) svc_q <= TPI_SVC_IDLE;
            end
            TPI_SVC_TRAP: begin
               if ((op.return_from_interrupt_op || op.return_and_skip_op) && !trap_pending_flag_q)
                  svc_q <= TPI_SVC_IDLE;
            end
            default: svc_q <= TPI_SVC_IDLE;
         endcase
      end
   end
   // trap and busy routine block maskable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) irq_req_q <= 1'b0;
      else if (ce) irq_req_q <= (ext_act | port_act) & ~trap_pending_flag_q & (svc_q == TPI_SVC_IDLE);
   end
   // ****************************************
   // wake from halt or idle
   // ****************************************
   // resume path chosen by enables
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_q     <= 1'b0;
         wake_isr_q <= 1'b0;
      end else if (ce) begin
         wake_q     <= low_power & port_any;
         wake_isr_q <= low_power & port_act;
      end
   end
   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_trap_set;
      ce && trap_fetch |=> trap_pending_flag_q;
   endproperty
   a_trap_set: assert property (p_trap_set) else $error("trap fetch did not set flag");
   property p_trap_clr;
      ce && op.clear_trap_pending_op && !trap_fetch |=> !trap_pending_flag_q;
   endproperty
   a_trap_clr: assert property (p_trap_clr) else $error("clear op left flag set");
   property p_trap_hold;
      ce && !op.clear_trap_pending_op && trap_pending_flag_q |=> trap_pending_flag_q;
   endproperty
   a_trap_hold: assert property (p_trap_hold) else $error("flag dropped without clear op");
   property p_zero_fill;
      ce && fetch.valid && !fetch.present |=> ir_q == 8'h00 && trap_ack_q;
   endproperty
   a_zero_fill: assert property (p_zero_fill) else $error("missing memory did not trap");
   property p_push;
      ce && trap_fetch |=> push_addr_q == $past(fetch.addr);
   endproperty
   a_push: assert property (p_push) else $error("wrong trap return address");
   property p_block;
      ce && trap_pending_flag_q |=> !irq_req_q;
   endproperty
   a_block: assert property (p_block) else $error("maskable request during trap");
   property p_vec_trap;
      ce && op.vector_select_op && trap_pending_flag_q |=> vec_valid_q && vec_low_q == 8'hfe;
   endproperty
   a_vec_trap: assert property (p_vec_trap) else $error("trap vector not fe");
   property p_vec_even;
      vec_valid_q |-> !vec_low_q[0] && vec_low_q >= 8'he0;
   endproperty
   a_vec_even: assert property (p_vec_even) else $error("vector byte out of range");
   property p_gate;
      irq_req_q |-> $past(global_irq_enable_q);
   endproperty
   a_gate: assert property (p_gate) else $error("request without global enable");
   property p_nopre;
      ce && svc_q == TPI_SVC_MASK |=> !irq_req_q;
   endproperty
   a_nopre: assert property (p_nopre) else $error("maskable preempted routine");
   property p_pop;
      ce && stack_pop && stack_ptr >= 8'h6f |=> pc_load_q && pc_load_addr_q == 15'h7fff;
   endproperty
   a_pop: assert property (p_pop) else $error("over-pop did not load top");
   c_trap: cover property (ce && trap_fetch ##[1:4] op.vector_select_op);
   c_port: cover property (svc_q == TPI_SVC_MASK && vec_low_q == 8'he2);
   c_wake: cover property (wake_q && !wake_isr_q);
   c_nest: cover property (svc_q == TPI_SVC_MASK ##1 svc_q == TPI_SVC_TRAP);
endmodule : tpi_top
`default_nettype wire

// ---- include/tpi_defines.svh ----
`ifndef TPI_DEFINES_SVH
`define TPI_DEFINES_SVH
// ****************************************
// apb map
// ****************************************
`define TPI_A_CTRL      8'h00
`define TPI_A_WAKE_EN   8'h04
`define TPI_A_WAKE_EDGE 8'h08
`define TPI_A_WAKE_PEND 8'h0c
`define TPI_A_STATUS    8'h10
`define TPI_B_GIE       0
`define TPI_B_PORT_GROUP_IRQ_ENABLE      1
`define TPI_B_EXT_IRQ_ENABLE      2
`define TPI_B_EXT_EDGE_POLARITY      3
`define TPI_B_EXT_IRQ_PENDING     4
// ****************************************
// codes
// ****************************************
`define TPI_TRAP_OP     8'h00
`define TPI_STACK_LIMIT 8'h6f
`define TPI_PC_TOP      15'h7fff
`define TPI_V_TRAP      8'hfe
`define TPI_V_EXT       8'hfa
`define TPI_V_PORT      8'he2
`define TPI_V_DEFAULT   8'he0
`endif

// ---- include/tpi_pkg.sv ----
package tpi_pkg;
   typedef enum logic [1:0] {
      TPI_SVC_IDLE = 2'b00,
      TPI_SVC_MASK = 2'b01,
      TPI_SVC_TRAP = 2'b11
   } tpi_svc_e;
   typedef struct packed {
      logic        valid;
      logic        present;
      logic [14:0] addr;
      logic [7:0]  data;
   } tpi_fetch_s;
   typedef struct packed {
      logic clear_trap_pending_op;
      logic vector_select_op;
      logic return_from_interrupt_op;
      logic return_and_skip_op;
   } tpi_op_s;
endpackage : tpi_pkg

// ---- hw/tpi_wake.sv ----
`timescale 1ns/1ps
`default_nettype none
module tpi_wake (
   // clock
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       ce,
   // pins and select
   input  wire logic [7:0] pins,
   input  wire logic [7:0] edge_sel,
   // software write of the latch
   input  wire logic       wr_en,
   input  wire logic [7:0] wr_data,
   // latch
   output logic      [7:0] pend_q
);
   logic [7:0] prev_q;
   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_pin
         logic hit;
         assign hit = edge_sel[i] ? (prev_q[i] & ~pins[i]) : (~prev_q[i] & pins[i]);
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) prev_q[i] <= 1'b0;
            else if (ce) prev_q[i] <= pins[i];
         end
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) pend_q[i] <= 1'b0;
            else if (ce) pend_q[i] <= hit | (wr_en ? wr_data[i] : pend_q[i]);
         end
      end
   endgenerate
endmodule : tpi_wake
`default_nettype wire

// ---- verif/tpi_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// core and pin model
// ****************************************
module tpi_core_model (
   // clock
   input  wire logic                 pclk,
   // reload from device
   input  wire logic                 pc_load_q,
   input  wire logic [14:0]          pc_load_addr_q,
   // core side
   output var tpi_pkg::tpi_fetch_s   fetch,
   output var tpi_pkg::tpi_op_s      op,
   output var logic                  stack_pop,
   output var logic [7:0]            stack_ptr,
   output var logic                  low_power,
   // pins
   output var logic                  ext_interrupt_pin,
   output var logic [7:0]            port_pins
);
   import tpi_pkg::*;
   logic [14:0] pc_q;
   initial begin
      fetch = '0;
      op = '0;
      stack_pop = 1'b0;
      stack_ptr = 8'h6f;
      low_power = 1'b0;
      ext_interrupt_pin = 1'b0;
      port_pins = 8'h00;
      pc_q = '0;
   end
   always @(posedge pclk) begin
      if (pc_load_q) begin
         pc_q <= pc_load_addr_q;
      end
   end
   // only the low 8k is fitted; absent words carry junk, the low address byte xor 5a
   task automatic fetch_at(input logic [14:0] a, input logic [7:0] d);
      logic p;
      p = a < 15'h2000;
      @(posedge pclk);
      fetch <= {1'b1, p, a, p ? d : (a[7:0] ^ 8'h5a)};
      @(posedge pclk);
      fetch <= {2'b00, ~a, ~d};
   endtask : fetch_at
   // waits for the reload to land before fetching
   task automatic fetch_pc;
      @(negedge pclk);
      fetch_at(pc_q, 8'hff);
   endtask : fetch_pc
   task automatic pulse(input tpi_op_s o);
      @(posedge pclk);
      op <= o;
      @(posedge pclk);
      op <= '0;
   endtask : pulse
   task automatic pop(input logic [7:0] p);
      @(posedge pclk);
      stack_pop <= 1'b1;
      stack_ptr <= p;
      @(posedge pclk);
      stack_pop <= 1'b0;
      stack_ptr <= p + 8'h02;
   endtask : pop
   task automatic set_pins(input logic e, input logic [7:0] p);
      @(posedge pclk);
      ext_interrupt_pin <= e;
      port_pins <= p;
   endtask : set_pins
   task automatic set_lp(input logic l);
      @(posedge pclk);
      low_power <= l;
   endtask : set_lp
endmodule : tpi_core_model
`default_nettype wire

// ---- verif/test_trap_and_port_edge_interrupts.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tpi_defines.svh"
// ****************************************
// bench
// ****************************************
module test_trap_and_port_edge_interrupts;
   import tpi_pkg::*;
   localparam tpi_op_s OP_CLR  = 4'b1000;
   localparam tpi_op_s OP_VSEL = 4'b0100;
   localparam tpi_op_s OP_RETURN_FROM_INTERRUPT_OP = 4'b0010;
   logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr, ir_q, vec_low_q, port_pins, stack_ptr;
   logic [31:0] pwdata, prdata, r;
   logic        e, trap_pending_flag_q, trap_ack_q, pc_load_q, irq_req_q, vec_valid_q;
   logic        wake_q, wake_isr_q, stack_pop, low_power, ext_interrupt_pin;
   logic [14:0] push_addr_q, pc_load_addr_q;
   tpi_fetch_s  fetch;
   tpi_op_s     op;
   int          err_total = 0;
   int          n_checks  = 0;
   int          cyc       = 0;
   tpi_top DUT (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .fetch, .op, .stack_pop, .stack_ptr, .low_power, .ir_q, .trap_pending_flag_q,
      .trap_ack_q, .push_addr_q, .pc_load_q, .pc_load_addr_q, .irq_req_q, .vec_valid_q,
      .vec_low_q, .wake_q, .wake_isr_q, .ext_interrupt_pin, .port_pins);
   tpi_core_model core (.pclk, .pc_load_q, .pc_load_addr_q, .fetch, .op, .stack_pop,
      .stack_ptr, .low_power, .ext_interrupt_pin, .port_pins);
   always #25 pclk = ~pclk;
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : print_verdict
   // a hung handshake ends here as a mismatch
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         print_verdict();
      end
   end
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      n_checks++;
      if (g !== x) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, x, g);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] x, input string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, x, r);
   endtask : rd
   task automatic settle;
      repeat (4) @(posedge pclk);
      @(negedge pclk);
   endtask : settle
   task automatic trap_end;
      core.pulse(OP_CLR);
      core.pulse(OP_RETURN_FROM_INTERRUPT_OP);
   endtask : trap_end
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      chk("flag", 0, trap_pending_flag_q);
      chk("vec_low", `TPI_V_DEFAULT, vec_low_q);
      rd(`TPI_A_CTRL, 0, "ctrl");
      wr(`TPI_A_STATUS, 32'hff);
      rd(`TPI_A_STATUS, 0, "status");
      apb(1'b0, 8'h14, 32'h0);
      chk("unmapped err", 1, e);
      chk("unmapped data", 0, r);
      chk("flag", 0, trap_pending_flag_q);
      $display("test reset done");
      wr(`TPI_A_CTRL, 32'h1);
      core.fetch_at(15'h0123, `TPI_TRAP_OP);
      @(negedge pclk);
      chk("ack", 1, trap_ack_q);
      chk("flag", 1, trap_pending_flag_q);
      chk("push", 15'h0123, push_addr_q);
      rd(`TPI_A_CTRL, 1, "ctrl gie");
      core.pulse(OP_VSEL);
      @(negedge pclk);
      chk("vec valid", 1, vec_valid_q);
      chk("vec trap", `TPI_V_TRAP, vec_low_q);
      rd(`TPI_A_STATUS, 3, "status trap");
      core.fetch_at(15'h0200, `TPI_TRAP_OP);
      @(negedge pclk);
      chk("ack nested", 1, trap_ack_q);
      chk("push nested", 15'h0200, push_addr_q);
      core.pulse(OP_RETURN_FROM_INTERRUPT_OP);
      @(negedge pclk);
      chk("flag", 1, trap_pending_flag_q);
      core.pulse(OP_CLR);
      @(negedge pclk);
      chk("flag", 0, trap_pending_flag_q);
      core.pulse(OP_CLR);
      core.pulse(OP_RETURN_FROM_INTERRUPT_OP);
      rd(`TPI_A_STATUS, 0, "status idle");
      $display("test trap done");
      core.pop(8'h6e);
      @(negedge pclk);
      chk("reload", 0, pc_load_q);
      core.pop(`TPI_STACK_LIMIT);
      @(negedge pclk);
      chk("reload", 1, pc_load_q);
      chk("reload addr", `TPI_PC_TOP, pc_load_addr_q);
      core.fetch_pc();
      @(negedge pclk);
      chk("ack absent", 1, trap_ack_q);
      chk("ir absent", 0, ir_q);
      core.pulse(OP_VSEL);
      trap_end();
      $display("test illegal fetch done");
      wr(`TPI_A_WAKE_EN, 32'hff);
      wr(`TPI_A_WAKE_EDGE, 32'h02);
      wr(`TPI_A_CTRL, 32'h03);
      core.set_pins(1'b0, 8'h01);
      settle();
      rd(`TPI_A_WAKE_PEND, 1, "pend");
      chk("irq", 1, irq_req_q);
      wr(`TPI_A_CTRL, 32'h01);
      settle();
      chk("irq no group", 0, irq_req_q);
      wr(`TPI_A_CTRL, 32'h02);
      settle();
      chk("irq no gie", 0, irq_req_q);
      wr(`TPI_A_CTRL, 32'h03);
      core.set_pins(1'b0, 8'h03);
      settle();
      rd(`TPI_A_WAKE_PEND, 1, "pend rise ignored");
      core.set_pins(1'b0, 8'h01);
      settle();
      rd(`TPI_A_WAKE_PEND, 3, "pend fall");
      core.pulse(OP_VSEL);
      @(negedge pclk);
      chk("vec port", `TPI_V_PORT, vec_low_q);
      rd(`TPI_A_STATUS, 1, "status mask");
      chk("irq in service", 0, irq_req_q);
      core.fetch_at(15'h0300, `TPI_TRAP_OP);
      @(negedge pclk);
      chk("ack preempt", 1, trap_ack_q);
      core.pulse(OP_VSEL);
      trap_end();
      core.pulse(OP_RETURN_FROM_INTERRUPT_OP);
      wr(`TPI_A_WAKE_PEND, 32'h0);
      settle();
      rd(`TPI_A_WAKE_PEND, 0, "pend steady pins");
      wr(`TPI_A_WAKE_EN, 32'h0);
      core.set_pins(1'b0, 8'h00);
      core.set_pins(1'b0, 8'h01);
      settle();
      chk("irq masked", 0, irq_req_q);
      $display("test port done");
      wr(`TPI_A_WAKE_EN, 32'hff);
      wr(`TPI_A_CTRL, 32'h01);
      wr(`TPI_A_WAKE_PEND, 32'h0);
      core.set_pins(1'b0, 8'h00);
      core.set_lp(1'b1);
      core.set_pins(1'b0, 8'h01);
      settle();
      chk("wake", 1, wake_q);
      chk("wake isr", 0, wake_isr_q);
      core.set_lp(1'b0);
      wr(`TPI_A_CTRL, 32'h03);
      wr(`TPI_A_WAKE_PEND, 32'h0);
      core.set_pins(1'b0, 8'h00);
      core.set_lp(1'b1);
      core.set_pins(1'b0, 8'h01);
      settle();
      chk("wake isr", 1, wake_isr_q);
      core.set_lp(1'b0);
      $display("test wake done");
      wr(`TPI_A_CTRL, 32'h0d);
      wr(`TPI_A_WAKE_PEND, 32'h0);
      core.set_pins(1'b1, 8'h01);
      core.set_pins(1'b0, 8'h01);
      settle();
      rd(`TPI_A_CTRL, 32'h1d, "ext pend");
      core.fetch_at(15'h0400, `TPI_TRAP_OP);
      core.pulse(OP_VSEL);
      @(negedge pclk);
      chk("vec trap first", `TPI_V_TRAP, vec_low_q);
      trap_end();
      core.pulse(OP_VSEL);
      @(negedge pclk);
      chk("vec ext", `TPI_V_EXT, vec_low_q);
      rd(`TPI_A_CTRL, 32'h1d, "ext pend kept");
      wr(`TPI_A_CTRL, 32'h0d);
      core.pulse(OP_RETURN_FROM_INTERRUPT_OP);
      core.pulse(OP_VSEL);
      @(negedge pclk);
      chk("vec default", `TPI_V_DEFAULT, vec_low_q);
      core.pulse(OP_RETURN_FROM_INTERRUPT_OP);
      $display("test priority done");
      ce <= 1'b0;
      core.fetch_at(15'h0500, `TPI_TRAP_OP);
      @(negedge pclk);
      chk("flag frozen", 0, trap_pending_flag_q);
      chk("ack frozen", 0, trap_ack_q);
      @(posedge pclk);
      ce <= 1'b1;
      $display("test clock enable done");
      print_verdict();
   end
endmodule : test_trap_and_port_edge_interrupts
`default_nettype wire
